// *** core/device_status_irq.sv ***
// Purpose: Device status byte, interrupt flags and command queue gate.
// Assumes: SPI pins are asynchronous; sclk is slower than i_clk_sys / 8.
// Notes:   Flags clear when a fetch transaction ends (slave select rises).
`timescale 1ns/100ps
`default_nettype none

module device_status_irq (
	// Clock, reset, enable
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	input  wire logic       i_clk_en,
	// SPI pins
	input  wire logic       i_sclk,
	input  wire logic       i_ss_n,
	input  wire logic       i_mosi,
	output logic            o_miso,
	output logic            o_miso_oe_n,
	// Ready/busy and interrupt pins
	input  wire logic       i_buffer_ready,
	output logic            o_ready_busy_n_pin,
	output logic            o_ready_busy_oe_n,
	output logic            o_irq_pin_n,
	output logic            o_irq_oe_n,
	// Interrupt enables
	input  wire logic [7:0] i_irq_enable_low_byte,
	input  wire logic [7:0] i_irq_enable_high_byte,
	// Command engine
	input  wire logic       i_voice_macro_busy,
	input  wire logic       i_cmd_done,
	input  wire logic       i_erase_ready,
	input  wire logic       i_erase_done,
	output logic            o_cmd_start,
	output logic [7:0]      o_cmd_code,
	// Byte one event pulses
	input  wire logic       i_pin_toggle,
	input  wire logic       i_protect_violation,
	input  wire logic       i_flash_write_done,
	input  wire logic       i_mem_overrun,
	input  wire logic       i_audio_done,
	input  wire logic       i_addr_error,
	input  wire logic       i_record_full,
	// Byte two level sources, timer and engine status
	input  wire logic [7:0] i_func_irq,
	input  wire logic       i_timer_event,
	input  wire logic       i_digital_loop_locked,
	input  wire logic       i_pll_locked,
	input  wire logic       i_decoding,
	input  wire logic       i_compressor_active
);

	// Commands allowed while powered down
	function automatic logic pd_allowed(input logic [7:0] code);
		pd_allowed = (code == status_irq_pkg::CMD_READ_STATUS) ||
			(code == status_irq_pkg::CMD_FETCH_INT) || (code == status_irq_pkg::CMD_WAKE);
	endfunction : pd_allowed

	// Commands handled here rather than by the engine
	function automatic logic is_local(input logic [7:0] code);
		is_local = pd_allowed(code) || (code == status_irq_pkg::CMD_POWER_DOWN);
	endfunction : is_local

	logic       sclk_s1, sclk_s2, sclk_s3;
	logic       ss_s1, ss_s2, ss_s3;
	logic       mosi_s1, mosi_s2;
	logic [7:0] rx_r, tx_r, flags1_r, flags2_r, queued_code_r;
	logic [2:0] bit_cnt_r, byte_cnt_r;
	logic       powered_down_r, rm_full_r, timer_flag_r, fetch_r;
	logic       cmd_processing_r, cmd_queue_full_r;

	// Synchronisers for the SPI pins
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{ss_s1, ss_s2, ss_s3}       <= 3'h7;
			{mosi_s1, mosi_s2}          <= 2'h0;
		end else if (i_clk_en) begin
			{sclk_s1, sclk_s2, sclk_s3} <= {i_sclk, sclk_s1, sclk_s2};
			{ss_s1, ss_s2, ss_s3}       <= {i_ss_n, ss_s1, ss_s2};
			{mosi_s1, mosi_s2}          <= {i_mosi, mosi_s1};
		end
	end

	// Link edges and framing
	wire        active    = ~ss_s2;
	wire        ss_fall   = ss_s3 & ~ss_s2;
	wire        ss_rise   = ~ss_s3 & ss_s2;
	wire        sclk_rise = active & sclk_s2 & ~sclk_s3;
	wire        sclk_fall = active & ~sclk_s2 & sclk_s3;
	wire [7:0]  rx_nxt    = {rx_r[6:0], mosi_s2};
	wire        byte_done = sclk_rise & (bit_cnt_r == status_irq_pkg::LAST_BIT);
	wire        cmd_valid = byte_done & (byte_cnt_r == 3'h0);
	wire        allowed   = ~powered_down_r | pd_allowed(rx_nxt);

	// Command classification
	wire        eng_cmd   = cmd_valid & allowed & ~is_local(rx_nxt);
	wire        is_erase  = (rx_nxt == status_irq_pkg::CMD_MSG_ERASE) ||
		(rx_nxt == status_irq_pkg::CMD_MEM_ERASE) || (rx_nxt == status_irq_pkg::CMD_CHIP_ERASE);
	wire        erase_bad = is_erase & ~i_erase_ready;
	wire        start_now = eng_cmd & ~cmd_processing_r & ~i_voice_macro_busy & ~erase_bad;
	wire        queue_it  = eng_cmd & cmd_processing_r & ~cmd_queue_full_r &
		~i_voice_macro_busy & ~erase_bad;
	wire        reject    = eng_cmd & ~start_now & ~queue_it;
	wire        launch    = cmd_queue_full_r & (i_cmd_done | ~cmd_processing_r);
	wire        do_fetch  = cmd_valid & allowed & (rx_nxt == status_irq_pkg::CMD_FETCH_INT);
	wire        do_pd     = cmd_valid & allowed & (rx_nxt == status_irq_pkg::CMD_POWER_DOWN);
	wire        do_wake   = cmd_valid & (rx_nxt == status_irq_pkg::CMD_WAKE);

	// Interrupt events, gated by the enables except the timer event
	wire        host_ovr  = sclk_rise & ~powered_down_r & ~o_ready_busy_n_pin;
	wire [7:0]  raw1      = {i_pin_toggle, i_protect_violation, i_flash_write_done, reject,
		host_ovr | i_mem_overrun, i_audio_done, i_addr_error, i_record_full};
	wire [7:0]  ev1       = raw1 & i_irq_enable_low_byte;
	wire [7:0]  ev2       = i_func_irq & i_irq_enable_high_byte;
	wire        clr       = fetch_r & ss_rise;
	wire [7:0]  flags1_nxt = (flags1_r & ~{8{clr}}) | ev1;
	wire [7:0]  flags2_nxt = (flags2_r & ~{8{clr}}) | ev2;
	wire        timer_nxt = (timer_flag_r & ~clr) | i_timer_event;
	wire        int_nxt   = (|flags1_nxt) | (|flags2_nxt) | timer_nxt;

	// Status bytes as shifted out
	wire        buf_ready = ~powered_down_r & o_ready_busy_n_pin;
	wire [7:0]  dev_status = {powered_down_r, buf_ready, ~o_irq_pin_n, rm_full_r, 1'b0,
		i_voice_macro_busy, cmd_queue_full_r, cmd_processing_r};
	wire [7:0]  timer_byte = {timer_flag_r, 2'h0, i_digital_loop_locked, 1'b0,
		i_pll_locked, i_decoding, i_compressor_active};
	wire [7:0]  next_byte = (fetch_r && byte_cnt_r == status_irq_pkg::IDX_FLAGS1) ? flags1_r :
		(fetch_r && byte_cnt_r == status_irq_pkg::IDX_FLAGS2) ? flags2_r :
		(fetch_r && byte_cnt_r == status_irq_pkg::IDX_TIMER) ? timer_byte : dev_status;

	// Serial shift and byte counting
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			rx_r       <= 8'h00;
			tx_r       <= 8'h00;
			bit_cnt_r  <= 3'h0;
			byte_cnt_r <= 3'h0;
		end else if (i_clk_en) begin
			if (ss_fall) begin
				tx_r       <= dev_status;
				bit_cnt_r  <= 3'h0;
				byte_cnt_r <= 3'h0;
			end else begin
				if (sclk_rise) begin
					rx_r      <= rx_nxt;
					bit_cnt_r <= bit_cnt_r + 3'h1;
				end
				if (byte_done && byte_cnt_r != status_irq_pkg::BYTE_SAT)
					byte_cnt_r <= byte_cnt_r + 3'h1;
				if (sclk_fall)
					tx_r <= (bit_cnt_r == 3'h0) ? next_byte : {tx_r[6:0], 1'b0};
			end
		end
	end

	// Power, fetch and memory-full state
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			powered_down_r <= status_irq_pkg::PD_RESET;
			fetch_r        <= 1'b0;
			rm_full_r      <= 1'b0;
		end else if (i_clk_en) begin
			if (do_pd)
				powered_down_r <= 1'b1;
			else if (do_wake)
				powered_down_r <= 1'b0;
			if (ss_fall)
				fetch_r <= 1'b0;
			else if (do_fetch)
				fetch_r <= 1'b1;
			rm_full_r <= i_record_full | (rm_full_r & ~i_erase_done);
		end
	end

	// Interrupt flags and pin
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			flags1_r     <= status_irq_pkg::FLAGS_RESET;
			flags2_r     <= status_irq_pkg::FLAGS_RESET;
			timer_flag_r <= 1'b0;
			o_irq_pin_n  <= 1'b1;
		end else if (i_clk_en) begin
			flags1_r     <= flags1_nxt;
			flags2_r     <= flags2_nxt;
			timer_flag_r <= timer_nxt;
			o_irq_pin_n  <= ~int_nxt;
		end
	end

	// Command queue and engine hand-off
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			cmd_processing_r <= 1'b0;
			cmd_queue_full_r <= 1'b0;
			queued_code_r    <= 8'h00;
			o_cmd_start      <= 1'b0;
			o_cmd_code       <= 8'h00;
		end else if (i_clk_en) begin
			cmd_processing_r <= start_now | launch | (cmd_processing_r & ~i_cmd_done);
			cmd_queue_full_r <= queue_it | (cmd_queue_full_r & ~launch);
			if (queue_it)
				queued_code_r <= rx_nxt;
			o_cmd_start <= start_now | launch;
			if (start_now)
				o_cmd_code <= rx_nxt;
			else if (launch)
				o_cmd_code <= queued_code_r;
		end
	end

	// Pin drivers; all released while powered down
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_miso             <= 1'b0;
			o_miso_oe_n        <= 1'b1;
			o_ready_busy_n_pin <= 1'b0;
			o_ready_busy_oe_n  <= 1'b1;
			o_irq_oe_n         <= 1'b1;
		end else if (i_clk_en) begin
			o_miso             <= tx_r[7];
			o_miso_oe_n        <= powered_down_r | ss_s2;
			o_ready_busy_n_pin <= i_buffer_ready;
			o_ready_busy_oe_n  <= powered_down_r;
			o_irq_oe_n         <= powered_down_r;
		end
	end

	// Checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst || !i_clk_en);

	pd_release_a: assert property (powered_down_r |=> o_miso_oe_n && o_irq_oe_n &&
		o_ready_busy_oe_n) else $error("pins driven while powered down");

	pd_ready_a: assert property (powered_down_r |-> !dev_status[6])
		else $error("buffer ready high while powered down");

	pd_discard_a: assert property (cmd_valid && powered_down_r && !pd_allowed(rx_nxt)
		|=> !$rose(cmd_processing_r) && !$rose(cmd_queue_full_r) && !$rose(flags1_r[4]))
		else $error("command taken in power-down");

	irq_pin_a: assert property ((|flags1_r) || (|flags2_r) |-> !o_irq_pin_n)
		else $error("irq pin not asserted with flags set");

	flag_hold_a: assert property (!clr |=> (flags1_r & $past(flags1_r)) == $past(flags1_r))
		else $error("flag dropped without fetch");

	enable_gate_a: assert property (!clr && flags1_r == 8'h00 &&
		(raw1 & i_irq_enable_low_byte) == 8'h00 |=> flags1_r == 8'h00)
		else $error("masked source raised a flag");

	level_rearm_a: assert property (clr && ev2 != 8'h00 |=> flags2_r != 8'h00 ##1 !o_irq_pin_n)
		else $error("level source lost on clear");

	queue_take_a: assert property (queue_it |=> cmd_queue_full_r &&
		queued_code_r == $past(rx_nxt)) else $error("command not queued");

	cmd_error_a: assert property (reject && i_irq_enable_low_byte[4] |=> flags1_r[4])
		else $error("dropped command raised no error");

	miso_first_a: assert property (ss_fall && !powered_down_r |-> ##2 o_miso == $past(dev_status[7], 2))
		else $error("status msb not first on miso");

	// Latched events and queued hand-off
	ovr_flag_a: assert property (host_ovr && i_irq_enable_low_byte[3] |=> flags1_r[3])
		else $error("host overrun not flagged");
	mem_full_a: assert property (i_record_full |=> rm_full_r)
		else $error("memory full not latched");
	queue_launch_a: assert property (launch |=>
		o_cmd_start && o_cmd_code == $past(queued_code_r))
		else $error("queued command not started");

	fetch_c: cover property (clr && flags1_r != 8'h00);
	queue_c: cover property (queue_it ##[1:200] launch);
	wake_c:  cover property (powered_down_r ##[1:400] !powered_down_r);
	error_c: cover property (reject);
	ovr_c:   cover property (host_ovr);

endmodule : device_status_irq

`default_nettype wire

// *** core/status_irq_pkg.sv ***
// Purpose: Shared constants for the device status and interrupt flag block.
// Assumes: Command codes are local choices; the SPI link runs in mode 0.
// Notes:   Bit positions index the status bytes shifted out on MISO.
package status_irq_pkg;
	// Command codes seen in the first byte of a transaction
	localparam logic [7:0] CMD_READ_STATUS = 8'h40;
	localparam logic [7:0] CMD_FETCH_INT   = 8'h46;
	localparam logic [7:0] CMD_WAKE        = 8'h10;
	localparam logic [7:0] CMD_POWER_DOWN  = 8'h12;
	localparam logic [7:0] CMD_MSG_ERASE   = 8'h2A;
	localparam logic [7:0] CMD_MEM_ERASE   = 8'h26;
	localparam logic [7:0] CMD_CHIP_ERASE  = 8'h24;

	// Device status byte fields
	localparam int ST_POWERED_DOWN = 7;
	localparam int ST_BUF_READY    = 6;
	localparam int ST_INT_PENDING  = 5;
	localparam int ST_MEM_FULL     = 4;
	localparam int ST_MACRO_BUSY   = 2;
	localparam int ST_QUEUE_FULL   = 1;
	localparam int ST_PROCESSING   = 0;

	// Interrupt status byte one fields
	localparam int F1_PIN_TOGGLE   = 7;
	localparam int F1_PROTECT      = 6;
	localparam int F1_WRITE_DONE   = 5;
	localparam int F1_CMD_ERROR    = 4;
	localparam int F1_OVERRUN      = 3;
	localparam int F1_CMD_DONE     = 2;
	localparam int F1_ADDR_ERROR   = 1;
	localparam int F1_RECORD_FULL  = 0;

	// Transfer framing
	localparam logic [2:0] LAST_BIT   = 3'h7;
	localparam logic [2:0] BYTE_SAT   = 3'h7;
	localparam logic [2:0] IDX_FLAGS1 = 3'h1;
	localparam logic [2:0] IDX_FLAGS2 = 3'h2;
	localparam logic [2:0] IDX_TIMER  = 3'h3;

	// Values after reset
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic       PD_RESET    = 1'b0;
endpackage : status_irq_pkg

// *** verif/spi_host_model.sv ***
// Purpose: Host controller model that runs SPI mode 0 frames.
// Assumes: One frame at a time, at most four bytes, sclk period 20 clocks.
// Notes:   A released MISO line reads as the inverse of its last bit.
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
	// Clock
	input  wire logic i_clk_sys,
	// Device side
	input  wire logic i_miso,
	input  wire logic i_miso_oe_n,
	// Host pins
	output logic      o_sclk,
	output logic      o_ss_n,
	output logic      o_mosi
);
	logic        line_r;
	logic [31:0] rx;

	// Pins idle at time zero
	initial begin
		o_sclk = 1'b0;
		o_ss_n = 1'b1;
		o_mosi = 1'b0;
		line_r = 1'b0;
		rx = 32'h0;
	end

	// Wait whole system clocks
	task automatic wait_clk(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask : wait_clk

	// Frame of n bytes from the top of tx, MISO read on each rise
	task automatic xfer(input logic [31:0] tx, input int n);
		int i;
		rx = 32'h0;
		@(posedge i_clk_sys);
		o_ss_n <= 1'b0;
		wait_clk(10);
		for (i = 0; i < 8 * n; i++) begin
			o_mosi <= tx[31 - i];
			wait_clk(10);
			o_sclk <= 1'b1;
			line_r = i_miso_oe_n ? ~line_r : i_miso;
			rx = {rx[30:0], line_r};
			wait_clk(10);
			o_sclk <= 1'b0;
		end
		wait_clk(10);
		o_ss_n <= 1'b1;
		o_mosi <= ~o_mosi;
		wait_clk(8);
	endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// *** verif/device_status_and_irq_flags_tb.sv ***
// Purpose: Self-checking bench for the status byte and interrupt flags.
// Assumes: Host model frames; engine and event sources driven here.
// Notes:   Timer byte levels held at 4'hD, giving 8'h15 when idle.
`timescale 1ns/100ps
`default_nettype none
module device_status_and_irq_flags_tb;
	typedef struct packed {
		logic [6:0] ev;
		logic [7:0] en1, func, en2, exp1, exp2;
	} row_t;
	localparam int LIMIT = 30000;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       buf_rdy = 1'b1, macro = 1'b0, done = 1'b0, tmr = 1'b0;
	logic       erase_rdy = 1'b1, erase_done = 1'b0;
	logic [6:0] ev = 7'h00;
	logic [7:0] en1 = 8'h00, en2 = 8'h00, func = 8'h00, last_code = 8'h00;
	logic [3:0] lv = 4'hD;
	wire        sclk, ss_n, mosi, miso, miso_oe_n, rb_pin, rb_oe_n, irq_n, irq_oe_n, start;
	wire  [7:0] code;
	int         n_errors = 0, n_checks = 0, cyc = 0, n_starts = 0, i;
	row_t       rows [10];

	// Clock and engine start monitor
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) if (start === 1'b1) begin
		n_starts++;
		last_code = code;
	end

	device_status_irq dut (.i_clk_sys(clk_sys), .i_rst(rst), .i_clk_en(1'b1), .i_sclk(sclk),
		.i_ss_n(ss_n), .i_mosi(mosi), .o_miso(miso), .o_miso_oe_n(miso_oe_n),
		.i_buffer_ready(buf_rdy), .o_ready_busy_n_pin(rb_pin), .o_ready_busy_oe_n(rb_oe_n),
		.o_irq_pin_n(irq_n), .o_irq_oe_n(irq_oe_n), .i_irq_enable_low_byte(en1),
		.i_irq_enable_high_byte(en2), .i_voice_macro_busy(macro), .i_cmd_done(done),
		.i_erase_ready(erase_rdy), .i_erase_done(erase_done), .o_cmd_start(start),
		.o_cmd_code(code), .i_pin_toggle(ev[6]), .i_protect_violation(ev[5]),
		.i_flash_write_done(ev[4]), .i_mem_overrun(ev[3]), .i_audio_done(ev[2]),
		.i_addr_error(ev[1]), .i_record_full(ev[0]), .i_func_irq(func), .i_timer_event(tmr),
		.i_digital_loop_locked(lv[3]), .i_pll_locked(lv[2]), .i_decoding(lv[1]),
		.i_compressor_active(lv[0]));
	spi_host_model host (.i_clk_sys(clk_sys), .i_miso(miso), .i_miso_oe_n(miso_oe_n),
		.o_sclk(sclk), .o_ss_n(ss_n), .o_mosi(mosi));

	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : tick
	task automatic send(input logic [7:0] b);
		host.xfer({b, 24'h0}, 1);
	endtask : send
	task automatic fetch;
		host.xfer({status_irq_pkg::CMD_FETCH_INT, 24'h0}, 4);
	endtask : fetch
	task automatic status(input logic [7:0] exp);
		send(status_irq_pkg::CMD_READ_STATUS);
		check(host.rx[7:0], exp);
	endtask : status
	task automatic complete_run;
		$display("Checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	// Hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_errors++;
			complete_run;
		end
	end

	// Main sequence
	initial begin
		rows[0] = '{7'h40, 8'hFF, 8'h00, 8'h00, 8'h80, 8'h00};
		rows[1] = '{7'h20, 8'hFF, 8'h00, 8'h00, 8'h40, 8'h00};
		rows[2] = '{7'h10, 8'hFF, 8'h00, 8'h00, 8'h20, 8'h00};
		rows[3] = '{7'h08, 8'hFF, 8'h00, 8'h00, 8'h08, 8'h00};
		rows[4] = '{7'h04, 8'hFF, 8'h00, 8'h00, 8'h04, 8'h00};
		rows[5] = '{7'h02, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h00};
		rows[6] = '{7'h01, 8'hFF, 8'h00, 8'h00, 8'h01, 8'h00};
		rows[7] = '{7'h7E, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
		rows[8] = '{7'h00, 8'h00, 8'hA5, 8'hFF, 8'h00, 8'hA5};
		rows[9] = '{7'h00, 8'h00, 8'hFF, 8'h0F, 8'h00, 8'h0F};
		tick(2);
		rst <= 1'b0;
		tick(2);
		check({5'h0, irq_n, start, miso_oe_n}, 8'h05);
		check(code, 8'h00);
		tick(3);
		for (i = 0; i < 10; i++) begin
			en1 <= rows[i].en1;
			en2 <= rows[i].en2;
			func <= rows[i].func;
			ev <= rows[i].ev;
			tick(1);
			ev <= 7'h00;
			tick(3);
			func <= 8'h00;
			tick(3);
			check({7'h0, irq_n}, {7'h0, ~|{rows[i].exp1, rows[i].exp2}});
			fetch;
			check(host.rx[31:24], {2'h1, |{rows[i].exp1, rows[i].exp2}, rows[i].ev[0], 4'h0});
			check(host.rx[23:16], rows[i].exp1);
			check(host.rx[15:8], rows[i].exp2);
			check(host.rx[7:0], 8'h15);
			check({7'h0, irq_n}, 8'h01);
			erase_done <= 1'b1;
			tick(1);
			erase_done <= 1'b0;
		end
		en1 <= 8'hFF;
		send(8'h55);
		send(8'h56);
		status(8'h43);
		send(8'h57);
		status(8'h63);
		done <= 1'b1;
		tick(1);
		done <= 1'b0;
		tick(3);
		check(last_code, 8'h56);
		done <= 1'b1;
		tick(1);
		done <= 1'b0;
		tick(3);
		status(8'h60);
		fetch;
		check(host.rx[23:16], 8'h10);
		macro <= 1'b1;
		send(8'h60);
		status(8'h64);
		macro <= 1'b0;
		fetch;
		check(host.rx[23:16], 8'h10);
		erase_rdy <= 1'b0;
		send(status_irq_pkg::CMD_MSG_ERASE);
		erase_rdy <= 1'b1;
		fetch;
		check(host.rx[23:16], 8'h10);
		send(status_irq_pkg::CMD_POWER_DOWN);
		check({5'h0, miso_oe_n, rb_oe_n, irq_oe_n}, 8'h07);
		send(8'h55);
		check(8'(n_starts), 8'h02);
		send(status_irq_pkg::CMD_WAKE);
		check({6'h0, rb_oe_n, irq_oe_n}, 8'h00);
		fetch;
		check(host.rx[31:24], 8'h40);
		check(host.rx[23:16], 8'h00);
		buf_rdy <= 1'b0;
		status(8'h00);
		check({7'h0, rb_pin}, 8'h00);
		buf_rdy <= 1'b1;
		en2 <= 8'hFF;
		func <= 8'h01;
		tick(4);
		fetch;
		check({7'h0, irq_n}, 8'h00);
		check(host.rx[23:16], 8'h08);
		func <= 8'h00;
		fetch;
		check(host.rx[15:8], 8'h01);
		tmr <= 1'b1;
		tick(1);
		tmr <= 1'b0;
		fetch;
		check(host.rx[15:8], 8'h00);
		check(host.rx[7:0], 8'h95);
		// Mid-run reset drops a pending timer flag
		tmr <= 1'b1;
		tick(1);
		tmr <= 1'b0;
		tick(2);
		check({7'h0, irq_n}, 8'h00);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(3);
		check({5'h0, irq_n, start, miso_oe_n}, 8'h05);
		fetch;
		check(host.rx[31:24], 8'h40);
		check(host.rx[7:0], 8'h15);
		complete_run;
	end
endmodule : device_status_and_irq_flags_tb
`default_nettype wire
